// ==== src/fst_defines.svh ====
// Constants for the flag skip test instruction block
`ifndef FST_DEFINES_SVH
`define FST_DEFINES_SVH
`define FST_OPC_W 10
`define FST_OPC_SKIP_PDN 10'h003
`define FST_OPC_SKIP_TMRA 10'h280
`define FST_OPC_SKIP_TMRB 10'h281
`define FST_IRQ_CTL_W 4
`define FST_TMRA_EN_BIT 2
`define FST_TMRB_EN_BIT 3
`define FST_FLAG_RESET 1'b0
`endif

// ==== src/fst_pkg.sv ====
// Types for the flag skip test instruction block
package fst_pkg;
    // Decoded test operations
    typedef enum logic [1:0] {
        FST_OP_NONE = 2'b00,
        FST_OP_PDN = 2'b01,
        FST_OP_TMRA = 2'b10,
        FST_OP_TMRB = 2'b11
    } fst_op_type;

    // Flag state seen by the sequencer
    typedef struct packed {
        logic powerdownFlag;
        logic timerARequestFlag;
        logic timerBRequestFlag;
    } fst_flags_type;
endpackage

// ==== src/fst_flag_skip_test.sv ====
// Skip-on-flag test instructions with power-down and timer request flags
`include "fst_defines.svh"
`timescale 1ns/10ps
module fst_flag_skip_test #(
    parameter int OPC_W = `FST_OPC_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Instruction stream from the sequencer
    input wire logic instrValid,
    input wire logic [OPC_W-1:0] instrCode,
    // Interrupt control and flag events
    input wire logic [`FST_IRQ_CTL_W-1:0] interruptControlFirst,
    input wire logic powerdownEntry,
    input wire logic powerdownFlagClear,
    input wire logic timerARequestSet,
    input wire logic timerBRequestSet,
    // Results to the sequencer
    output logic skipNext,
    output logic suppressExec,
    output fst_pkg::fst_flags_type flags
);
    // Opcode compares are fixed-width, so refuse any other width at elaboration
    if (OPC_W != `FST_OPC_W) begin : gBadOpcWidth
        $error("fst_flag_skip_test: OPC_W must be 10");
    end

    logic powerdownFlag_r;
    logic timerARequestFlag_r;
    logic timerBRequestFlag_r;
    logic powerdownFlag_nxt;
    logic timerARequestFlag_nxt;
    logic timerBRequestFlag_nxt;
    logic skipPending_r;
    logic suppress_r;
    fst_pkg::fst_op_type op;
    logic skipNow;
    logic clearA;
    logic clearB;
    logic timerAEnable;
    logic timerBEnable;

    // Behaviour notes for users of this block
    // - One instruction per cycle at most, marked by instrValid
    // - Decision uses flag values held before the taking edge
    // - A set request and a skip clear in one cycle: set wins
    // - Reason: losing a fresh request would drop an interrupt
    // - Power-down entry and external clear together: entry wins
    // - Power-down test reads only; flag changes solely by pins
    // - Skip is owed until the next valid word arrives
    // - Gaps with instrValid low keep the owed skip pending
    // - The swallowed word takes no action, even a test opcode
    // - Hence a test sitting in a skipped slot clears nothing
    // - Enable bit high turns the timer test into a no-op
    // - No-op means no skip and no flag change at all
    // - skipNext stands one cycle after the deciding edge
    // - suppressExec stands one cycle after the swallowed word
    // - flags lag the internal registers by one cycle
    // - Limitation: flag view on flags is one cycle stale
    // - Trade-off: registered outputs cost that cycle of lag
    // - Sequencer still advances its counter over the swallowed word
    // - So a skip costs a slot but no extra fetch
    // - Codes outside the three tests decode to no operation
    // - Opcode width is fixed; other widths are refused
    // - Enable bits come straight from the control port
    // - No interrupt logic lives here; flags only
    // - Reset clears every flag and any owed skip
    // - Reset is synchronous and active high
    // - First instruction may arrive at the first edge after reset
    // - Back to back instructions are allowed
    // - A skip directly after a skip cannot occur
    // - Reason: the pending skip blocks the next decision
    // - Timer flags are set by one-cycle pulses
    // - A held set pulse keeps the flag high each cycle
    // - Clear pulse for power-down is also one cycle
    // - Decode is a function so both paths share it
    // - All registers load on every edge except skipPending_r, which loads only when instrValid is high
    // - Outputs come straight from flip-flops
    // - Combinational next values keep priority in one place
    // - Each flag has its own process for clarity
    // - Hazard: a test and a swallow in one slot are exclusive
    // - Hazard: enable changes apply at the next taken test
    // - Control bits are sampled as levels, not edges
    // - No buffering beyond the pending skip bit
    // - Single clock domain throughout
    // - Inputs are taken as synchronous to mclk

    // Instruction decode, used for both valid and suppressed slots
    function automatic fst_pkg::fst_op_type decodeOp(input logic [OPC_W-1:0] code);
        unique case (code)
            `FST_OPC_SKIP_PDN: decodeOp = fst_pkg::FST_OP_PDN;
            `FST_OPC_SKIP_TMRA: decodeOp = fst_pkg::FST_OP_TMRA;
            `FST_OPC_SKIP_TMRB: decodeOp = fst_pkg::FST_OP_TMRB;
            default: decodeOp = fst_pkg::FST_OP_NONE;
        endcase
    endfunction

    assign timerAEnable = interruptControlFirst[`FST_TMRA_EN_BIT];
    assign timerBEnable = interruptControlFirst[`FST_TMRB_EN_BIT];

    // Skip decision; a suppressed instruction takes no action itself
    always_comb begin
        op = decodeOp(instrCode);
        skipNow = 1'b0;
        clearA = 1'b0;
        clearB = 1'b0;
        if (instrValid && !skipPending_r) begin
            unique case (op)
                fst_pkg::FST_OP_PDN: begin
                    skipNow = powerdownFlag_r;
                end
                fst_pkg::FST_OP_TMRA: begin
                    skipNow = !timerAEnable && timerARequestFlag_r;
                    clearA = skipNow;
                end
                fst_pkg::FST_OP_TMRB: begin
                    skipNow = !timerBEnable && timerBRequestFlag_r;
                    clearB = skipNow;
                end
                fst_pkg::FST_OP_NONE: begin
                    skipNow = 1'b0;
                end
            endcase
        end
    end

    // Power-down next value; only entry and external clear touch it, never a test
    always_comb begin
        powerdownFlag_nxt = powerdownFlag_r;
        if (powerdownEntry) begin
            powerdownFlag_nxt = 1'b1;
        end else if (powerdownFlagClear) begin
            powerdownFlag_nxt = 1'b0;
        end
    end

    // Power-down flag register
    always_ff @(posedge mclk) begin
        if (reset) begin
            powerdownFlag_r <= `FST_FLAG_RESET;
        end else begin
            powerdownFlag_r <= powerdownFlag_nxt;
        end
    end

    // Timer A next value; a new request beats the test's clear
    always_comb begin
        timerARequestFlag_nxt = timerARequestFlag_r;
        if (timerARequestSet) begin
            timerARequestFlag_nxt = 1'b1;
        end else if (clearA) begin
            timerARequestFlag_nxt = 1'b0;
        end
    end

    // Timer A request flag register
    always_ff @(posedge mclk) begin
        if (reset) begin
            timerARequestFlag_r <= `FST_FLAG_RESET;
        end else begin
            timerARequestFlag_r <= timerARequestFlag_nxt;
        end
    end

    // Timer B next value; set wins over clear
    always_comb begin
        timerBRequestFlag_nxt = timerBRequestFlag_r;
        if (timerBRequestSet) begin
            timerBRequestFlag_nxt = 1'b1;
        end else if (clearB) begin
            timerBRequestFlag_nxt = 1'b0;
        end
    end

    // Timer B request flag register
    always_ff @(posedge mclk) begin
        if (reset) begin
            timerBRequestFlag_r <= `FST_FLAG_RESET;
        end else begin
            timerBRequestFlag_r <= timerBRequestFlag_nxt;
        end
    end

    // Skip pending until the next valid instruction has been swallowed
    always_ff @(posedge mclk) begin
        if (reset) begin
            skipPending_r <= 1'b0;
            suppress_r <= 1'b0;
        end else if (instrValid) begin
            skipPending_r <= skipNow;
            suppress_r <= skipPending_r;
        end else begin
            suppress_r <= 1'b0;
        end
    end

    // Registered outputs
    always_ff @(posedge mclk) begin
        if (reset) begin
            skipNext <= 1'b0;
            flags <= '0;
        end else begin
            skipNext <= skipNow;
            flags.powerdownFlag <= powerdownFlag_r;
            flags.timerARequestFlag <= timerARequestFlag_r;
            flags.timerBRequestFlag <= timerBRequestFlag_r;
        end
    end

    assign suppressExec = suppress_r;
endmodule // fst_flag_skip_test

// ==== verification/fst_seq_model.sv ====
// Sequencer model that advances the program counter
`timescale 1ns/10ps
module fst_seq_model (
    // Clock, reset and fetch
    input wire logic mclk,
    input wire logic reset,
    input wire logic instrValid,
    // Program counter
    output logic [9:0] pc
);
    // Swallowed words still move the counter on, so the skip costs no extra fetch
    always_ff @(posedge mclk) begin
        pc <= reset ? 10'h000 : pc + {9'h000, instrValid};
    end
endmodule // fst_seq_model

// ==== verification/fst_checker.sv ====
// Port assertions for the flag skip test block
`include "fst_defines.svh"
`timescale 1ns/10ps
module fst_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Inputs watched
    input wire logic instrValid,
    input wire logic [`FST_OPC_W-1:0] instrCode,
    input wire logic [`FST_IRQ_CTL_W-1:0] interruptControlFirst,
    input wire logic powerdownFlagClear,
    input wire logic timerARequestSet,
    input wire logic timerBRequestSet,
    // Results
    input wire logic skipNext,
    input wire logic suppressExec,
    input wire fst_pkg::fst_flags_type flags
);
    logic pend_r;
    wire live = skipNext | pend_r;
    wire isP = instrCode == `FST_OPC_SKIP_PDN;
    wire isA = instrCode == `FST_OPC_SKIP_TMRA;
    wire isB = instrCode == `FST_OPC_SKIP_TMRB;
    // A skip stays owed across gaps until a valid word arrives
    always_ff @(posedge mclk) begin
        pend_r <= !reset && live && !instrValid;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    chk_skip_cause: assert property (
        skipNext |-> $past(instrValid && !live && (isP || isA || isB))) else $error("bad skip");
    chk_swallow_next: assert property (
        suppressExec == $past(live && instrValid)) else $error("bad suppress");
    chk_pdn_keep: assert property (
        skipNext && $past(isP && !powerdownFlagClear) |=> flags.powerdownFlag) else $error("pd lost");
    chk_tmra_clear: assert property (
        skipNext && $past(isA && !timerARequestSet) |=> !flags.timerARequestFlag) else $error("A kept");
    chk_tmrb_clear: assert property (
        skipNext && $past(isB && !timerBRequestSet) |=> !flags.timerBRequestFlag) else $error("B kept");
    chk_tmra_masked: assert property (
        instrValid && isA && interruptControlFirst[`FST_TMRA_EN_BIT] |=> !skipNext)
        else $error("A not nop");
    chk_tmrb_masked: assert property (
        instrValid && isB && interruptControlFirst[`FST_TMRB_EN_BIT] |=> !skipNext)
        else $error("B not nop");
    chk_skip_single: assert property (
        skipNext |=> !skipNext) else $error("long skip");
    cover property (skipNext && $past(isP));
    cover property (suppressExec && $past(isA));
    cover property (instrValid && isB && interruptControlFirst[3]);
endmodule // fst_checker
bind fst_flag_skip_test fst_checker CHK (.mclk(mclk), .reset(reset), .instrValid(instrValid),
    .instrCode(instrCode), .interruptControlFirst(interruptControlFirst),
    .powerdownFlagClear(powerdownFlagClear), .timerARequestSet(timerARequestSet),
    .timerBRequestSet(timerBRequestSet), .skipNext(skipNext), .suppressExec(suppressExec),
    .flags(flags));

// ==== verification/fst_flag_skip_test_bench.sv ====
// Bench for the flag skip test block
`include "fst_defines.svh"
`timescale 1ns/10ps
module fst_flag_skip_test_bench;
    logic mclk = 0, reset = 1, instrValid = 0, skipNext, suppressExec;
    logic [9:0] instrCode = 10'h000, pcount;
    logic [3:0] ctl = 4'h0, ev = 4'h0;
    fst_pkg::fst_flags_type flags;
    int mismatches = 0, compares = 0, nOps = 0;
    always #5 mclk = ~mclk;
    fst_flag_skip_test DUT (.mclk(mclk), .reset(reset), .instrValid(instrValid),
        .instrCode(instrCode), .interruptControlFirst(ctl), .powerdownEntry(ev[3]),
        .powerdownFlagClear(ev[2]), .timerARequestSet(ev[1]), .timerBRequestSet(ev[0]),
        .skipNext(skipNext), .suppressExec(suppressExec), .flags(flags));
    fst_seq_model SEQ (.mclk(mclk), .reset(reset), .instrValid(instrValid), .pc(pcount));
    task chk(input string n, input logic [9:0] e, input logic [9:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task end_sim;
        if (mismatches == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // One-cycle flag event pulse
    task pulse(input logic [3:0] e);
        @(posedge mclk) ev <= e;
        @(posedge mclk) ev <= 4'h0;
    endtask
    // One instruction; {skipNext, suppressExec} judged once it was taken
    task op(input logic [9:0] c, input logic [1:0] e, input string n);
        nOps++;
        @(posedge mclk) instrValid <= 1'b1;
        instrCode <= c;
        @(posedge mclk) instrValid <= 1'b0;
        #1 chk(n, {8'h00, e}, {8'h00, skipNext, suppressExec});
    endtask
    // Flags lag the internal state by a cycle, so let two edges pass
    task flg(input int i, input logic e);
        repeat (2) @(posedge mclk);
        #1 chk("flag", {9'h000, e}, {9'h000, flags[i]});
    endtask
    task t_pdn;
        pulse(4'h8);
        op(`FST_OPC_SKIP_PDN, 2'b10, "pskip");
        op(10'h000, 2'b01, "pswal");
        flg(2, 1'b1);
        pulse(4'h4);
        op(`FST_OPC_SKIP_PDN, 2'b00, "pkeep");
        op(10'h000, 2'b00, "pnext");
    endtask
    // Timer test: b 0 is timer A, 1 is timer B
    task t_tmr(input int b);
        logic [9:0] c;
        c = b ? `FST_OPC_SKIP_TMRB : `FST_OPC_SKIP_TMRA;
        pulse(b ? 4'h9 : 4'hA);
        op(`FST_OPC_SKIP_PDN, 2'b10, "pset");
        op(c, 2'b01, "refuse");
        flg(1 - b, 1'b1);
        @(posedge mclk) ctl <= b ? 4'h8 : 4'h4;
        op(c, 2'b00, "mask");
        op(10'h000, 2'b00, "mnext");
        flg(1 - b, 1'b1);
        @(posedge mclk) ctl <= 4'h0;
        op(c, 2'b10, "tskip");
        op(c, 2'b01, "tswal");
        flg(1 - b, 1'b0);
        pulse(4'h4);
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        t_pdn;
        t_tmr(0);
        t_tmr(1);
        chk("pc", nOps[9:0], pcount);
        end_sim;
    end
    // Watchdog at 2000 cycles, far beyond the under one hundred cycles the tests need
    initial begin
        #20000;
        mismatches++;
        end_sim;
    end
endmodule // fst_flag_skip_test_bench
